/* design/upfp_pkg.sv */
// Package for the USB parallel FIFO port: timing counts, sizes, modes, carriers.
// Assumes a single 50 MHz core clock; flag gap and wake times become cycle counts here, the timeout stays in milliseconds.
package upfp_pkg;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // Least flag-inactive time after a strobe cycle, rounded up to cycles
  localparam int unsigned FLAG_GAP_NS = 80;
  localparam int unsigned FLAG_GAP_CYC = (FLAG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least low time on the wake input while suspended
  localparam int unsigned WAKE_MS = 20;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam int unsigned WAKE_CYC = WAKE_MS * CYC_PER_MS;
  // Receive flush timeout, in milliseconds
  localparam logic [7:0] TMO_DEFAULT_MS = 8'h10;
  localparam logic [7:0] TMO_MIN_MS = 8'h02;
  // Buffer depths
  localparam int unsigned RX_DEPTH = 128;
  localparam int unsigned TX_DEPTH = 256;
  localparam int unsigned RX_AW = 7;
  localparam int unsigned TX_AW = 8;
  // Counter widths
  localparam int unsigned GAP_W = 4;
  localparam int unsigned MS_W = 16;
  localparam int unsigned WAKE_W = 24;
  localparam logic [GAP_W-1:0] GAP_LOAD = GAP_W'(FLAG_GAP_CYC);
  localparam logic [MS_W-1:0] MS_LAST = MS_W'(CYC_PER_MS - 1);
  // Port modes
  typedef enum logic [1:0] {
    UPFP_MODE_FIFO,
    UPFP_MODE_ABB,
    UPFP_MODE_SBB
  } upfp_mode_t;
  // One byte travelling with its valid
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } upfp_byte_t;
endpackage : upfp_pkg

/* design/upfp_fifo.sv */
// Byte FIFO in flip-flops with valid/ready on both sides and a flush input.
// Assumes one clock domain; depth is a power of two given by the address width.
`timescale 1ns/100ps
`default_nettype none
module upfp_fifo
  import upfp_pkg::*;
#(
  parameter int unsigned AW = 7
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic flush_i,
  input wire upfp_byte_t wr_i,
  output logic wr_ready_o,
  input wire logic rd_ready_i,
  output upfp_byte_t rd_o,
  output logic [AW:0] count_o
);
  logic [7:0] mem_r [2**AW]; // Storage array
  logic [AW:0] wp_r, wp_nxt; // Write pointer with wrap bit
  logic [AW:0] rp_r, rp_nxt; // Read pointer with wrap bit
  logic do_wr, do_rd;

  assign count_o = wp_r - rp_r;
  assign wr_ready_o = (count_o != (AW+1)'(2**AW)); // Honest full
  assign rd_o.valid = (count_o != '0); // Honest empty
  assign rd_o.data = mem_r[rp_r[AW-1:0]];
  assign do_wr = wr_i.valid && wr_ready_o;
  assign do_rd = rd_ready_i && rd_o.valid;

  // Pointer next values; flush drops everything stored
  always_comb begin
    wp_nxt = wp_r + (AW+1)'(do_wr);
    rp_nxt = rp_r + (AW+1)'(do_rd);
    if (flush_i) begin
      rp_nxt = wp_nxt;
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Data array has no reset; contents are qualified by the pointers
  always_ff @(posedge core_clk_i) begin
    if (do_wr) begin
      mem_r[wp_r[AW-1:0]] <= wr_i.data;
    end
  end
endmodule : upfp_fifo
`default_nettype wire

/* design/upfp_port.sv */
// Parallel strobe/flag FIFO port: receive and transmit buffers, flush timer,
// bit-bang modes, remote-wake detector and a fixed identifier.
// Assumes strobes are synchronous to core_clk_i; the USB side is a byte stream.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Receive flag inactive 80 ns after read
// - Write byte captured at strobe fall
// - Space flag inactive 80 ns after write
// - Async bit-bang paces bytes by timer
// - Sync bit-bang samples pins on write
// - Fixed identifier readable from USB only
// - Receive flush timeout 16 ms, 2-255
// - Suspended wake low 20 ms requests resume
// - Remote wake enabled by default
// - Single reference clock drives FIFO logic
// - 128-byte receive buffer, read pops one
// - 256-byte transmit buffer drained by USB
// - Reset at power-up and external pin
// - Low receive flag means byte waiting
// - Read strobe fall fetches and drives byte
// - Space flag low permits write
// - Write strobe fall stores bus byte
module upfp_port
  import upfp_pkg::*;
#(
  parameter logic [63:0] CHIP_ID = 64'h1234_5678_9abc_def0, // Arbitrary value
  parameter int unsigned WAKE_CYCLES = WAKE_CYC,
  parameter int unsigned MS_CYCLES = CYC_PER_MS // Core cycles per millisecond tick
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic rd_n_i,
  input wire logic wr_i,
  input wire logic [7:0] fifo_data_bus_i,
  output logic [7:0] fifo_data_bus_o,
  output logic fifo_data_bus_oe_o,
  input wire logic rx_available_n_i,
  output logic rx_available_n_o,
  output logic rx_available_n_oe_o,
  output logic tx_space_n_o,
  output logic tx_space_n_oe_o,
  input wire upfp_byte_t usb_out_i,
  output logic usb_out_ready_o,
  input wire logic usb_in_ready_i,
  output upfp_byte_t usb_in_o,
  input wire upfp_mode_t mode_i,
  input wire logic [7:0] bb_dir_i,
  input wire logic [15:0] bb_div_i,
  input wire logic tmo_wr_i,
  input wire logic [7:0] tmo_ms_i,
  input wire logic suspend_i,
  input wire logic wake_en_wr_i,
  input wire logic wake_en_i,
  output logic resume_req_o,
  output logic [63:0] chip_id_o,
  output logic [7:0] tmo_ms_o
);
  // Strobe synchronisers and previous samples
  logic rd_s1_r, rd_s2_r, rd_s3_r, wr_s1_r, wr_s2_r, wr_s3_r;
  // Bus samples kept in step with the write synchroniser, so the byte is the one at the fall
  logic [7:0] dat_s1_r, dat_s2_r, dat_s3_r;
  localparam logic [MS_W-1:0] MS_TICK_LAST = MS_W'(MS_CYCLES - 1); // Last count of a tick
  logic rd_fall, rd_rise, wr_fall;
  logic [GAP_W-1:0] rgap_r, rgap_nxt, tgap_r, tgap_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic [7:0] tmo_r, tmo_nxt;
  logic [MS_W-1:0] ms_r, ms_nxt;
  logic [7:0] msc_r, msc_nxt;
  logic [15:0] bbc_r, bbc_nxt;
  logic [WAKE_W-1:0] wk_r, wk_nxt;
  logic wake_en_r, wake_en_nxt, res_r, res_nxt, wake_pin;
  upfp_byte_t rx_head, tx_push;
  logic rx_pop, rx_flush, tx_ready;
  logic [RX_AW:0] rx_cnt;
  logic [TX_AW:0] tx_cnt;
  logic fifo_mode, wake_mode;

  // Cascaded 50 MHz core stands in for the 12 MHz reference
  // Fast clock generation lives outside this block
  assign fifo_mode = (mode_i == UPFP_MODE_FIFO);
  assign wake_mode = suspend_i && wake_en_r;

  // Edge detectors look only at the second and third stages
  assign rd_fall = !rd_s2_r && rd_s3_r;
  assign rd_rise = rd_s2_r && !rd_s3_r;
  assign wr_fall = !wr_s2_r && wr_s3_r;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_s1_r <= 1'b1;
      rd_s2_r <= 1'b1;
      rd_s3_r <= 1'b1;
      wr_s1_r <= 1'b0;
      wr_s2_r <= 1'b0;
      wr_s3_r <= 1'b0;
      dat_s1_r <= 8'h00;
      dat_s2_r <= 8'h00;
      dat_s3_r <= 8'h00;
    end else begin
      rd_s1_r <= rd_n_i;
      rd_s2_r <= rd_s1_r;
      rd_s3_r <= rd_s2_r;
      wr_s1_r <= wr_i;
      wr_s2_r <= wr_s1_r;
      wr_s3_r <= wr_s2_r;
      dat_s1_r <= fifo_data_bus_i;
      dat_s2_r <= dat_s1_r;
      dat_s3_r <= dat_s2_r;
    end
  end

  // Receive buffer, filled from the OUT endpoint
  upfp_fifo #(.AW(RX_AW)) u_rx (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(rx_flush),
    .wr_i(usb_out_i),
    .wr_ready_o(usb_out_ready_o),
    .rd_ready_i(rx_pop),
    .rd_o(rx_head),
    .count_o(rx_cnt)
  );

  // Transmit buffer, drained by IN requests
  upfp_fifo #(.AW(TX_AW)) u_tx (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .flush_i(1'b0),
    .wr_i(tx_push),
    .wr_ready_o(tx_ready),
    .rd_ready_i(usb_in_ready_i),
    .rd_o(usb_in_o),
    .count_o(tx_cnt)
  );

  // Pops: FIFO mode on read fall, async bit-bang on timer tick, sync bit-bang every cycle
  always_comb begin
    rx_pop = 1'b0;
    if (fifo_mode) begin
      rx_pop = rd_fall && (rgap_r == '0);
    end else if (mode_i == UPFP_MODE_ABB) begin
      rx_pop = (bbc_r == '0);
    end else begin
      rx_pop = 1'b1; // Sync mode drives each byte as it arrives
    end
  end

  // Transmit pushes: strobe fall in FIFO mode, pin sample in sync bit-bang
  always_comb begin
    tx_push.valid = 1'b0;
    tx_push.data = fifo_data_bus_i;
    if (fifo_mode) begin
      tx_push.valid = wr_fall && (tgap_r == '0);
      tx_push.data = dat_s3_r; // Byte seen while strobe was last high
    end else if (mode_i == UPFP_MODE_SBB) begin
      tx_push.valid = rx_head.valid; // Sample as a byte is written out
    end
  end

  // Output data, flag gap timers and bit-bang pacing
  always_comb begin
    dout_nxt = dout_r;
    rgap_nxt = (rgap_r != '0) ? rgap_r - 1'b1 : rgap_r;
    tgap_nxt = (tgap_r != '0) ? tgap_r - 1'b1 : tgap_r;
    bbc_nxt = (bbc_r != '0) ? bbc_r - 1'b1 : bb_div_i;
    if (rx_pop && rx_head.valid) begin
      dout_nxt = rx_head.data;
    end
    if (fifo_mode && rd_rise) begin
      rgap_nxt = GAP_LOAD;
    end
    if (fifo_mode && wr_fall) begin
      tgap_nxt = GAP_LOAD;
    end
    if (mode_i != UPFP_MODE_ABB || !rx_head.valid) begin
      bbc_nxt = bb_div_i;
    end
  end

  // Flush timeout: millisecond tick then timeout counter
  always_comb begin
    tmo_nxt = tmo_r;
    ms_nxt = (ms_r == MS_TICK_LAST) ? '0 : ms_r + 1'b1;
    msc_nxt = msc_r;
    rx_flush = 1'b0;
    if (tmo_wr_i && tmo_ms_i >= TMO_MIN_MS) begin
      tmo_nxt = tmo_ms_i;
    end
    if (rx_pop || usb_out_i.valid || rx_cnt == '0) begin
      msc_nxt = '0;
      ms_nxt = '0;
    end else if (ms_r == MS_TICK_LAST) begin
      if (msc_r + 8'h01 >= tmo_r) begin
        rx_flush = 1'b1;
        msc_nxt = '0;
      end else begin
        msc_nxt = msc_r + 8'h01;
      end
    end
  end

  // Wake detector: pin low long enough while suspended
  assign wake_pin = rx_available_n_i;
  always_comb begin
    wk_nxt = '0;
    res_nxt = 1'b0;
    wake_en_nxt = wake_en_wr_i ? wake_en_i : wake_en_r;
    if (wake_mode && !wake_pin) begin
      wk_nxt = (wk_r == WAKE_W'(WAKE_CYCLES)) ? wk_r : wk_r + 1'b1;
      res_nxt = (wk_r == WAKE_W'(WAKE_CYCLES - 1));
    end
  end

  // State registers; reset from the pin covers power-up too
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_r <= 8'h00;
      rgap_r <= '0;
      tgap_r <= '0;
      bbc_r <= '0;
      tmo_r <= TMO_DEFAULT_MS;
      ms_r <= '0;
      msc_r <= 8'h00;
      wk_r <= '0;
      res_r <= 1'b0;
      wake_en_r <= 1'b1;
    end else begin
      dout_r <= dout_nxt;
      rgap_r <= rgap_nxt;
      tgap_r <= tgap_nxt;
      bbc_r <= bbc_nxt;
      tmo_r <= tmo_nxt;
      ms_r <= ms_nxt;
      msc_r <= msc_nxt;
      wk_r <= wk_nxt;
      res_r <= res_nxt;
      wake_en_r <= wake_en_nxt;
    end
  end

  // Pins: flags gated by gap timers; data bus driven while reading in FIFO mode, per bb_dir in bit-bang
  always_comb begin
    rx_available_n_o = !(rx_head.valid && rgap_r == '0 && rd_s3_r);
    tx_space_n_o = !(tx_ready && tgap_r == '0 && !wr_s3_r);
    rx_available_n_oe_o = fifo_mode && !wake_mode; // Pin turns input
    tx_space_n_oe_o = fifo_mode;
    fifo_data_bus_o = dout_r;
    fifo_data_bus_oe_o = 1'b0;
    if (fifo_mode) begin
      fifo_data_bus_oe_o = !rd_s3_r;
    end else begin
      fifo_data_bus_oe_o = |bb_dir_i; // Per-pin direction folded to one enable
      fifo_data_bus_o = dout_r & bb_dir_i;
    end
  end

  assign resume_req_o = res_r;
  assign chip_id_o = CHIP_ID; // Constant, USB side only
  assign tmo_ms_o = tmo_r;

  // Receive flag stays inactive for the full gap after a read
  a_rx_gap_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (fifo_mode && rd_rise) |=> rx_available_n_o [*4])
    else $error("receive flag active too soon after read");
  // Space flag stays inactive after a write
  a_tx_gap_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (fifo_mode && wr_fall) |=> tx_space_n_o [*4])
    else $error("space flag active too soon after write");
  // Accepted read fetches the head byte onto the bus
  a_rd_fetch: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (fifo_mode && rx_pop && rx_head.valid) |=> fifo_data_bus_o == $past(rx_head.data))
    else $error("read did not fetch head byte");
  // Write fall with space pushes bus byte
  a_wr_store: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (fifo_mode && wr_fall && tgap_r == '0 && tx_ready) |=> tx_cnt == $past(tx_cnt) + 1'b1
      || $past(usb_in_ready_i))
    else $error("write byte not stored");
  // Bus driven only while read strobe is low in FIFO mode
  a_bus_drive: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    fifo_mode |-> (fifo_data_bus_oe_o == !rd_s3_r))
    else $error("bus drive outside read");
  // Timeout stays within legal range
  a_tmo_range: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    tmo_r >= TMO_MIN_MS)
    else $error("timeout out of range");
  // Resume pulses only after a long low in wake mode
  a_wake_req: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    resume_req_o |-> $past(wake_mode) && $past(wk_r) == WAKE_W'(WAKE_CYCLES - 1))
    else $error("resume without long wake low");
  // One pop per read strobe
  a_rd_once: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    (fifo_mode && rx_pop) |=> !rx_pop)
    else $error("read popped twice");
endmodule : upfp_port
`default_nettype wire

/* sim/upfp_host_model.sv */
// External logic on the strobe/flag side: reads and writes single bytes.
// Assumes the bench resolves the shared pins; tasks start and end 2 ns after an edge.
`timescale 1ns/100ps
`default_nettype none
module upfp_host_model (
  input wire logic core_clk_i,
  input wire logic rx_available_n_i,
  input wire logic tx_space_n_i,
  input wire logic [7:0] bus_i,
  output logic rd_n_o,
  output logic wr_o,
  output logic [7:0] bus_o
);
  // Strobes idle, pins quiet
  initial begin
    rd_n_o = 1'b1;
    wr_o = 1'b0;
    bus_o = 8'h00;
  end
  task automatic step();
    @(posedge core_clk_i);
    #2;
  endtask : step
  // Counts high cycles of a flag until it drops; the bound stops a hang
  task automatic flag_wait(input logic is_rx, output int unsigned hi);
    hi = 0;
    while ((is_rx ? rx_available_n_i : tx_space_n_i) !== 1'b0 && hi < 12) begin
      step();
      hi++;
    end
  endtask : flag_wait
  task automatic read_byte(output logic [7:0] d, output int unsigned hi);
    flag_wait(1'b1, hi); // Strobe once a byte waits, or after 12 cycles at most
    rd_n_o = 1'b0;
    repeat (6) step(); // Low for 120 ns
    d = bus_i;
    rd_n_o = 1'b1;
    flag_wait(1'b1, hi);
    if (hi < 7) repeat (7 - hi) step(); // Pre-charge covers 50 ns plus flag gap
  endtask : read_byte
  task automatic write_byte(input logic [7:0] d, output int unsigned hi);
    flag_wait(1'b0, hi); // Write once space is shown, or after 12 cycles at most
    bus_o = d;
    wr_o = 1'b1;
    repeat (3) step(); // High 60 ns, data set up well before the fall
    wr_o = 1'b0;
    step();
    bus_o = ~d; // Released pins must not look like the old byte
    flag_wait(1'b0, hi);
    hi++;
    step(); // Low time between pulses stays above 50 ns
  endtask : write_byte
  task automatic drive_pins(input logic [7:0] v);
    bus_o = v;
  endtask : drive_pins
endmodule : upfp_host_model
`default_nettype wire

/* sim/upfp_port_tb.sv */
// Self-checking bench: strobe reads and writes, USB streams, timeout, wake, bit-bang.
// Assumes the design package and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module upfp_port_tb;
  import upfp_pkg::*;
  localparam int unsigned WAKE_SIM = 20; // Short wake span keeps the run brief
  localparam int unsigned MS_SIM = 20; // Short millisecond tick makes the flush reachable
  localparam logic [63:0] ID_VAL = 64'h0f1e_2d3c_4b5a_6978; // Arbitrary value
  logic core_clk, reset_n, rd_n, wr, bus_oe, rx_n, rx_oe, tx_n, tx_oe, rx_pin;
  logic usb_out_ready, usb_in_ready, tmo_wr, suspend, wake_en_wr, wake_en, resume, wake_drv;
  logic [7:0] bus_out, host_bus, bus_pin, drv_mask, bb_dir, tmo_ms, tmo_now, rd_data;
  logic [15:0] bb_div;
  logic [63:0] chip_id;
  upfp_byte_t usb_out, usb_in;
  upfp_mode_t mode;
  int unsigned error_cnt, comparisons, hi, cnt, pulses;
  // Pin level: device bits where it drives, host bits elsewhere
  assign drv_mask = !bus_oe ? 8'h00 : (mode == UPFP_MODE_FIFO) ? 8'hff : bb_dir;
  assign bus_pin = (drv_mask & bus_out) | (~drv_mask & host_bus);
  assign rx_pin = rx_oe ? rx_n : wake_drv;
  upfp_port #(.CHIP_ID(ID_VAL), .WAKE_CYCLES(WAKE_SIM), .MS_CYCLES(MS_SIM)) u_upfp_port (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .rd_n_i(rd_n), .wr_i(wr),
    .fifo_data_bus_i(bus_pin), .fifo_data_bus_o(bus_out), .fifo_data_bus_oe_o(bus_oe),
    .rx_available_n_i(rx_pin), .rx_available_n_o(rx_n), .rx_available_n_oe_o(rx_oe),
    .tx_space_n_o(tx_n), .tx_space_n_oe_o(tx_oe), .usb_out_i(usb_out),
    .usb_out_ready_o(usb_out_ready), .usb_in_ready_i(usb_in_ready), .usb_in_o(usb_in),
    .mode_i(mode), .bb_dir_i(bb_dir), .bb_div_i(bb_div), .tmo_wr_i(tmo_wr),
    .tmo_ms_i(tmo_ms), .suspend_i(suspend), .wake_en_wr_i(wake_en_wr),
    .wake_en_i(wake_en), .resume_req_o(resume), .chip_id_o(chip_id), .tmo_ms_o(tmo_now));
  upfp_host_model u_upfp_host_model (
    .core_clk_i(core_clk), .rx_available_n_i(rx_pin), .tx_space_n_i(tx_n),
    .bus_i(bus_pin), .rd_n_o(rd_n), .wr_o(wr), .bus_o(host_bus));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic step();
    @(posedge core_clk);
    #2;
  endtask : step
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Valid held until the edge that sees ready high
  task automatic usb_send(input logic [7:0] b);
    usb_out = '{valid: 1'b1, data: b};
    for (cnt = 0; usb_out_ready !== 1'b1 && cnt < 50; cnt++) step();
    chk(usb_out_ready, 1'b1);
    step();
    usb_out.valid = 1'b0;
    step(); // Valid stays low across one edge before the next byte
  endtask : usb_send
  task automatic usb_recv(input logic [7:0] exp);
    for (cnt = 0; usb_in.valid !== 1'b1 && cnt < 50; cnt++) step();
    chk({usb_in.valid, usb_in.data}, {1'b1, exp});
    usb_in_ready = 1'b1;
    step();
    usb_in_ready = 1'b0;
    step(); // Ready stays low across one edge before the next pop
  endtask : usb_recv
  task automatic tmo_set(input logic [7:0] v, input logic [7:0] exp);
    tmo_ms = v;
    tmo_wr = 1'b1;
    step();
    tmo_wr = 1'b0;
    step();
    chk(tmo_now, exp);
  endtask : tmo_set
  // Holds the wake pin low for len cycles and counts resume pulses
  task automatic wake_pulse(input int unsigned len);
    pulses = 0;
    wake_drv = 1'b0;
    for (int i = 0; i < len + 8; i++) begin
      if (i == len) wake_drv = 1'b1;
      step();
      if (resume === 1'b1) pulses++;
    end
  endtask : wake_pulse
  // About 6k cycles expected; nearly seven times that means a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    {reset_n, tmo_wr, suspend, wake_en_wr, wake_en, usb_in_ready} = '0;
    {bb_dir, tmo_ms, bb_div} = '0;
    wake_drv = 1'b1;
    usb_out = '0;
    mode = UPFP_MODE_FIFO;
    repeat (8) @(posedge core_clk);
    #2;
    reset_n = 1'b1;
    repeat (3) step();
    chk(tmo_now, TMO_DEFAULT_MS);
    chk(chip_id, ID_VAL);
    chk({rx_n, tx_n, resume}, 3'b100);
    chk({rx_oe, tx_oe}, 2'b11);
    // Receive buffer filled until it refuses, then read back by strobe
    for (int i = 0; i < RX_DEPTH; i++) usb_send(8'(i) ^ 8'ha5);
    chk(usb_out_ready, 1'b0);
    for (int i = 0; i < RX_DEPTH; i++) begin
      u_upfp_host_model.read_byte(rd_data, hi);
      chk(rd_data, 8'(i) ^ 8'ha5);
      chk(hi >= FLAG_GAP_CYC, 1'b1);
    end
    chk(rx_n, 1'b1);
    // Transmit buffer written full, then drained from the USB side
    for (int i = 0; i < TX_DEPTH; i++) begin
      u_upfp_host_model.write_byte(8'(i) ^ 8'h3c, hi);
      chk(hi >= FLAG_GAP_CYC, 1'b1);
    end
    chk(tx_n, 1'b1);
    for (int i = 0; i < TX_DEPTH; i++) usb_recv(8'(i) ^ 8'h3c);
    tmo_set(8'h01, 8'h10);
    tmo_set(8'h02, 8'h02);
    tmo_set(8'hff, 8'hff);
    // Reset in mid-run restores the default timeout
    reset_n = 1'b0;
    repeat (8) step();
    reset_n = 1'b1;
    step();
    chk(tmo_now, 8'h10);
    suspend = 1'b1;
    step();
    chk(rx_oe, 1'b0);
    wake_pulse(WAKE_SIM - 5);
    chk(pulses, 0);
    wake_pulse(WAKE_SIM + 8);
    chk(pulses, 1);
    wake_en_wr = 1'b1;
    step();
    wake_en_wr = 1'b0;
    step();
    chk(rx_oe, 1'b1);
    suspend = 1'b0;
    // Async bit-bang: queued bytes leave one timer period apart
    usb_send(8'h3c);
    usb_send(8'hc3);
    bb_dir = 8'hff;
    bb_div = 16'h0009;
    mode = UPFP_MODE_ABB;
    for (cnt = 0; bus_out !== 8'h3c && cnt < 100; cnt++) step();
    for (cnt = 0; bus_out !== 8'hc3 && cnt < 100; cnt++) step();
    chk(cnt, 32'(bb_div) + 1);
    chk(bus_oe, 1'b1);
    chk(tx_oe, 1'b0);
    // Sync bit-bang: exactly one pin sample per byte written
    bb_dir = 8'h00;
    mode = UPFP_MODE_SBB;
    for (int i = 0; i < 2; i++) begin
      u_upfp_host_model.drive_pins(i ? 8'h69 : 8'h96);
      usb_send(8'h11);
      usb_recv(i ? 8'h69 : 8'h96);
    end
    repeat (20) step();
    chk(usb_in.valid, 1'b0);
    // Flush: a lone byte left unread is dropped after the default timeout
    mode = UPFP_MODE_FIFO;
    usb_send(8'h5a);
    repeat (TMO_DEFAULT_MS * MS_SIM - 40) step();
    chk(rx_n, 1'b0);
    repeat (60) step();
    chk(rx_n, 1'b1);
    wrap_up();
  end
endmodule : upfp_port_tb
`default_nettype wire
